/* hdl/bidir_msg_engine.v */
// bidirectional message engine: framing, checking, responses
// Summary of operation
// - reply NAK on any receive error from length to checksum
// - on error discard until ENQ; length dropped only on length or length-byte error
// - ENQ 05, ACK 06, NAK 15 codes
// - insert control bytes, hide received ones
// - length is two bytes, words or bytes
// - send length as written, low byte first
// - store valid received length, low byte first
// - data bytes pass untranslated
// - send area read in ascending order
// - receive area written in ascending order
// - checksum is 16-bit sum of length, data
// - checksum omitted when disable setting is 1
// - check received sum; skip extra bytes
// - error codes 0001 to 00ff
// - sent NAK code stored in receive error
// - received NAK code stored in send error
// - both valid: await response, answer message
// - send invalid: report code 3, no wait
// - receive invalid: discard silently, no answer
// - policy upper byte send, lower receive
// - timeout in 100ms units, zero disables
`timescale 1ns/1ps
`include "msg_defs.vh"
module bidir_msg_engine #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input  wire        core_clk,          // module clock, 20 MHz
   input  wire        arst_n,            // asynchronous reset, active low
   input  wire [11:0] cpu_addr,          // buffer memory word address
   input  wire        cpu_wr,            // cpu write strobe
   input  wire        cpu_rd,            // cpu read strobe
   input  wire [15:0] cpu_wdata,         // cpu write data
   output reg  [15:0] cpu_rdata,         // cpu read data, next cycle
   input  wire        send_request,      // program asks for a send
   output reg         send_complete_bit, // send finished, see send error
   output reg         recv_read_request, // received message ready
   input  wire        recv_read_done,    // program has read the message
   input  wire [7:0]  rx_data,           // received byte
   input  wire        rx_valid,          // received byte strobe
   input  wire        rx_error,          // line error on this byte
   output reg  [7:0]  tx_data,           // byte to transmit
   output reg         tx_valid,          // byte offered
   input  wire        tx_ready           // byte taken when valid
);
   localparam T_IDLE = 4'd0, T_ENQ = 4'd1, T_LLO = 4'd2, T_LHI = 4'd3, T_DATA = 4'd4,
              T_CLO = 4'd5, T_CHI = 4'd6, T_END = 4'd7, T_RESP = 4'd8, T_RLO = 4'd9,
              T_RHI = 4'd10;
   localparam R_IDLE = 4'd0, R_LLO = 4'd1, R_LHI = 4'd2, R_DATA = 4'd3, R_CLO = 4'd4,
              R_CHI = 4'd5, R_SKIP = 4'd6, R_DISC = 4'd7, R_NLO = 4'd8, R_NHI = 4'd9;

   reg         rst_meta, rst_n_sync;
   reg  [15:0] unit_reg, send_head_reg, send_len_reg, recv_head_reg, recv_len_reg;
   reg  [15:0] mode_reg, timeout_reg, policy_reg, sum_off_reg, send_err_reg, recv_err_reg;
   reg  [3:0]  tx_state, rx_state;
   reg  [16:0] tx_left, rx_left;
   reg  [11:0] tx_ptr, rx_ptr;
   reg  [15:0] tx_sum, rx_sum, resp_code, rx_len;
   reg         tx_hi, rx_hi, awaiting, coll_tx, rx_drop, resp_pend;
   reg  [7:0]  rx_lo;
   reg         eng_we;
   reg  [11:0] eng_waddr;
   reg  [15:0] eng_wdata;
   wire [15:0] cpu_q, eng_q;
   wire        expired;

   wire special   = (cpu_addr >= `ADR_SPECIAL_LO) && (cpu_addr <= `ADR_SPECIAL_HI);
   wire word_unit = (unit_reg == `UNIT_WORD);
   wire sum_on    = (sum_off_reg != `SUM_DISABLED);
   wire send_inv  = (policy_reg[15:8] == `POLICY_INVALID);
   wire recv_inv  = (policy_reg[7:0] == `POLICY_INVALID);
   wire active    = (mode_reg == `MODE_BIDIR);
   wire tx_free   = !tx_valid || tx_ready;
   wire tx_msg    = (tx_state >= T_ENQ && tx_state <= T_END) || awaiting;
   wire rx_msg    = (rx_state >= R_LLO && rx_state <= R_CHI);
   wire [15:0] rx_word = {rx_data, rx_len[7:0]};
   wire [16:0] rx_need = word_unit ? {1'b0, rx_word} : ({1'b0, rx_word} + 17'd1) >> 1;
   wire tmr_start = (tx_state == T_END) && !(coll_tx && send_inv);
   wire tmr_stop  = !awaiting;

   function [16:0] byte_count;
      input [15:0] len;
      input        words;
      begin
         byte_count = words ? {len, 1'b0} : {1'b0, len};
      end
   endfunction

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta   <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   buffer_ram u_ram (
      .clk       (core_clk),
      .cpu_we    (cpu_wr && !special),
      .cpu_addr  (cpu_addr),
      .cpu_wdata (cpu_wdata),
      .cpu_q     (cpu_q),
      .eng_we    (eng_we),
      .eng_waddr (eng_waddr),
      .eng_wdata (eng_wdata),
      .eng_raddr (tx_ptr),
      .eng_q     (eng_q)
   );

   tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tmr (
      .clk     (core_clk),
      .rst_n   (rst_n_sync),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .limit   (timeout_reg),
      .expired (expired)
   );

   always @(posedge core_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cpu_rdata <= 16'h0000;
         unit_reg <= `RST_UNIT;           send_head_reg <= `RST_SEND_HEAD;
         send_len_reg <= `RST_SEND_LEN;   recv_head_reg <= `RST_RECV_HEAD;
         recv_len_reg <= `RST_RECV_LEN;   mode_reg <= `RST_MODE;
         timeout_reg <= `RST_TIMEOUT;     policy_reg <= `RST_POLICY;
         sum_off_reg <= `RST_SUM_OFF;     send_err_reg <= `RST_ERR;
         recv_err_reg <= `RST_ERR;
         send_complete_bit <= 1'b0;       recv_read_request <= 1'b0;
         tx_data <= 8'h00;   tx_valid <= 1'b0;   tx_state <= T_IDLE;   rx_state <= R_IDLE;
         tx_left <= 17'd0;   rx_left <= 17'd0;   tx_ptr <= 12'h000;    rx_ptr <= 12'h000;
         tx_sum <= 16'h0000; rx_sum <= 16'h0000; resp_code <= 16'h0000; rx_len <= 16'h0000;
         tx_hi <= 1'b0;      rx_hi <= 1'b0;      awaiting <= 1'b0;     coll_tx <= 1'b0;
         rx_drop <= 1'b0;    resp_pend <= 1'b0;  rx_lo <= 8'h00;
         eng_we <= 1'b0;     eng_waddr <= 12'h000; eng_wdata <= 16'h0000;
      end else begin
         eng_we <= 1'b0;
         if (cpu_rd) begin
            if (special) begin
               if (cpu_addr == `ADR_UNIT) cpu_rdata <= unit_reg;
               else if (cpu_addr == `ADR_SEND_HEAD) cpu_rdata <= send_head_reg;
               else if (cpu_addr == `ADR_SEND_LEN) cpu_rdata <= send_len_reg;
               else if (cpu_addr == `ADR_RECV_HEAD) cpu_rdata <= recv_head_reg;
               else if (cpu_addr == `ADR_RECV_LEN) cpu_rdata <= recv_len_reg;
               else if (cpu_addr == `ADR_MODE) cpu_rdata <= mode_reg;
               else if (cpu_addr == `ADR_TIMEOUT) cpu_rdata <= timeout_reg;
               else if (cpu_addr == `ADR_POLICY) cpu_rdata <= policy_reg;
               else if (cpu_addr == `ADR_SUM_OFF) cpu_rdata <= sum_off_reg;
               else if (cpu_addr == `ADR_SEND_ERR) cpu_rdata <= send_err_reg;
               else if (cpu_addr == `ADR_RECV_ERR) cpu_rdata <= recv_err_reg;
               else cpu_rdata <= 16'h0000;
            end else begin
               cpu_rdata <= cpu_q;
            end
         end
         if (cpu_wr) begin
            if (cpu_addr == `ADR_UNIT) unit_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_SEND_HEAD) send_head_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_SEND_LEN) send_len_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_RECV_HEAD) recv_head_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_RECV_LEN) recv_len_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_MODE) mode_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_TIMEOUT) timeout_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_POLICY) policy_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_SUM_OFF) sum_off_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_SEND_ERR) send_err_reg <= cpu_wdata;
            else if (cpu_addr == `ADR_RECV_ERR) recv_err_reg <= cpu_wdata;
         end
         // handshake drops only after the program lowers its request
         if (send_complete_bit && !send_request)
            send_complete_bit <= 1'b0;
         if (recv_read_done)
            recv_read_request <= 1'b0;
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;

         // transmit side: responses take priority at message boundaries
         case (tx_state)
            T_IDLE: begin
               tx_ptr <= send_head_reg[11:0];
               if (resp_pend) begin
                  tx_state <= T_RESP;
               end else if (active && send_request && !send_complete_bit && !awaiting) begin
                  tx_sum   <= 16'h0000;
                  tx_hi    <= 1'b0;
                  coll_tx  <= 1'b0;
                  tx_state <= T_ENQ;
               end
            end
            T_ENQ: if (tx_free) begin
               tx_data <= `CODE_ENQ; tx_valid <= 1'b1; tx_state <= T_LLO;
            end
            T_LLO: if (tx_free) begin
               tx_data  <= eng_q[7:0]; tx_valid <= 1'b1;
               tx_sum   <= tx_sum + {8'h00, eng_q[7:0]};
               tx_left  <= byte_count(eng_q, word_unit);
               tx_state <= T_LHI;
            end
            T_LHI: if (tx_free) begin
               tx_data  <= eng_q[15:8]; tx_valid <= 1'b1;
               tx_sum   <= tx_sum + {8'h00, eng_q[15:8]};
               tx_ptr   <= tx_ptr + 12'h001;
               tx_state <= (tx_left != 17'd0) ? T_DATA : (sum_on ? T_CLO : T_END);
            end
            T_DATA: if (tx_free) begin
               tx_data  <= tx_hi ? eng_q[15:8] : eng_q[7:0];
               tx_valid <= 1'b1;
               tx_sum   <= tx_sum + {8'h00, (tx_hi ? eng_q[15:8] : eng_q[7:0])};
               tx_hi    <= !tx_hi;
               if (tx_hi)
                  tx_ptr <= tx_ptr + 12'h001;
               tx_left  <= tx_left - 17'd1;
               if (tx_left == 17'd1)
                  tx_state <= sum_on ? T_CLO : T_END;
            end
            T_CLO: if (tx_free) begin
               tx_data <= tx_sum[7:0]; tx_valid <= 1'b1; tx_state <= T_CHI;
            end
            T_CHI: if (tx_free) begin
               tx_data <= tx_sum[15:8]; tx_valid <= 1'b1; tx_state <= T_END;
            end
            T_END: begin
               if (coll_tx && send_inv) begin
                  send_err_reg      <= `ERR_SIMUL;
                  send_complete_bit <= 1'b1;
               end else begin
                  awaiting <= 1'b1;
               end
               tx_state <= T_IDLE;
            end
            T_RESP: if (tx_free) begin
               tx_data   <= (resp_code == `ERR_NONE) ? `CODE_ACK : `CODE_NAK;
               tx_valid  <= 1'b1;
               resp_pend <= 1'b0;
               recv_err_reg <= resp_code;
               if (resp_code == `ERR_NONE) begin
                  recv_read_request <= 1'b1;
                  tx_state <= T_IDLE;
               end else begin
                  tx_state <= T_RLO;
               end
            end
            T_RLO: if (tx_free) begin
               tx_data <= resp_code[7:0]; tx_valid <= 1'b1; tx_state <= T_RHI;
            end
            T_RHI: if (tx_free) begin
               tx_data <= resp_code[15:8]; tx_valid <= 1'b1; tx_state <= T_IDLE;
            end
            default: tx_state <= T_IDLE;
         endcase

         // awaiting a response: timeout, or collision with send invalid
         if (awaiting && expired) begin
            awaiting <= 1'b0; send_err_reg <= `ERR_TIMEOUT; send_complete_bit <= 1'b1;
         end else if (awaiting && coll_tx && send_inv) begin
            awaiting <= 1'b0; send_err_reg <= `ERR_SIMUL; send_complete_bit <= 1'b1;
         end

         // receive side
         if (rx_valid && rx_error && rx_msg) begin
            rx_state <= R_DISC;
            if (!rx_drop) begin
               resp_pend <= 1'b1; resp_code <= `ERR_LINE;
            end
         end else if (rx_valid) begin
            case (rx_state)
               R_IDLE, R_SKIP, R_DISC: begin
                  if (rx_data == `CODE_ENQ) begin
                     rx_sum   <= 16'h0000;
                     rx_drop  <= tx_msg && recv_inv;
                     if (tx_msg)
                        coll_tx <= 1'b1;
                     rx_state <= R_LLO;
                  end else if (rx_state != R_DISC && awaiting) begin
                     if (rx_data == `CODE_ACK) begin
                        awaiting <= 1'b0; send_err_reg <= `ERR_NONE; send_complete_bit <= 1'b1;
                        rx_state <= R_IDLE;
                     end else if (rx_data == `CODE_NAK) begin
                        rx_state <= R_NLO;
                     end
                  end
               end
               R_LLO: begin
                  rx_len[7:0] <= rx_data;
                  rx_sum      <= rx_sum + {8'h00, rx_data};
                  rx_state    <= R_LHI;
               end
               R_LHI: begin
                  rx_sum <= rx_sum + {8'h00, rx_data};
                  if (rx_word == 16'h0000 || rx_need + 17'd1 > {1'b0, recv_len_reg}) begin
                     rx_state <= R_DISC;
                     if (!rx_drop) begin
                        resp_pend <= 1'b1; resp_code <= `ERR_LEN;
                     end
                  end else begin
                     if (!rx_drop) begin
                        eng_we <= 1'b1; eng_waddr <= recv_head_reg[11:0]; eng_wdata <= rx_word;
                     end
                     rx_left  <= byte_count(rx_word, word_unit);
                     rx_ptr   <= recv_head_reg[11:0] + 12'h001;
                     rx_hi    <= 1'b0;
                     rx_state <= R_DATA;
                  end
               end
               R_DATA: begin
                  rx_sum <= rx_sum + {8'h00, rx_data};
                  rx_hi  <= !rx_hi;
                  if (!rx_hi)
                     rx_lo <= rx_data;
                  if (!rx_drop && (rx_hi || rx_left == 17'd1)) begin
                     eng_we    <= 1'b1;
                     eng_waddr <= rx_ptr;
                     eng_wdata <= rx_hi ? {rx_data, rx_lo} : {8'h00, rx_data};
                  end
                  if (rx_hi)
                     rx_ptr <= rx_ptr + 12'h001;
                  rx_left <= rx_left - 17'd1;
                  if (rx_left == 17'd1) begin
                     if (sum_on) begin
                        rx_state <= R_CLO;
                     end else begin
                        rx_state <= R_SKIP;
                        if (!rx_drop) begin
                           resp_pend <= 1'b1; resp_code <= `ERR_NONE;
                        end
                     end
                  end
               end
               R_CLO: begin
                  rx_lo <= rx_data; rx_state <= R_CHI;
               end
               R_CHI: begin
                  rx_state <= R_IDLE;
                  if (!rx_drop) begin
                     resp_pend <= 1'b1;
                     resp_code <= ({rx_data, rx_lo} == rx_sum) ? `ERR_NONE : `ERR_SUM;
                  end
               end
               R_NLO: begin
                  rx_lo <= rx_data; rx_state <= R_NHI;
               end
               R_NHI: begin
                  awaiting <= 1'b0; send_err_reg <= {rx_data, rx_lo};
                  send_complete_bit <= 1'b1; rx_state <= R_IDLE;
               end
               default: rx_state <= R_IDLE;
            endcase
         end
      end
   end
endmodule // bidir_msg_engine

/* hdl/buffer_ram.v */
// shared buffer memory: cpu port and engine ports
`timescale 1ns/1ps
module buffer_ram (
   input  wire        clk,       // core clock
   input  wire        cpu_we,    // cpu write strobe
   input  wire [11:0] cpu_addr,  // cpu word address
   input  wire [15:0] cpu_wdata, // cpu write data
   output wire [15:0] cpu_q,     // cpu read data
   input  wire        eng_we,    // engine write strobe
   input  wire [11:0] eng_waddr, // engine write address
   input  wire [15:0] eng_wdata, // engine write data
   input  wire [11:0] eng_raddr, // engine read address
   output wire [15:0] eng_q      // engine read data
);
   reg [15:0] mem [0:4095];

   // engine write is last, so it wins a same-address clash
   always @(posedge clk) begin
      if (cpu_we)
         mem[cpu_addr] <= cpu_wdata;
      if (eng_we)
         mem[eng_waddr] <= eng_wdata;
   end

   assign cpu_q = mem[cpu_addr];
   assign eng_q = mem[eng_raddr];
endmodule // buffer_ram

/* hdl/msg_defs.vh */
// constants for the bidirectional message engine
`ifndef MSG_DEFS_VH
`define MSG_DEFS_VH

// control bytes
`define CODE_ENQ        8'h05
`define CODE_ACK        8'h06
`define CODE_NAK        8'h15

// special area word addresses
`define ADR_SPECIAL_LO  12'h100
`define ADR_SPECIAL_HI  12'h11f
`define ADR_UNIT        12'h103
`define ADR_SEND_HEAD   12'h104
`define ADR_SEND_LEN    12'h105
`define ADR_RECV_HEAD   12'h106
`define ADR_RECV_LEN    12'h107
`define ADR_MODE        12'h112
`define ADR_TIMEOUT     12'h113
`define ADR_POLICY      12'h114
`define ADR_SUM_OFF     12'h115
`define ADR_SEND_ERR    12'h116
`define ADR_RECV_ERR    12'h117

// reset values
`define RST_UNIT        16'h0000
`define RST_SEND_HEAD   16'h0000
`define RST_SEND_LEN    16'h0080
`define RST_RECV_HEAD   16'h0080
`define RST_RECV_LEN    16'h0080
`define RST_MODE        16'h0000
`define RST_TIMEOUT     16'h0000
`define RST_POLICY      16'h0000
`define RST_SUM_OFF     16'h0000
`define RST_ERR         16'h0000

// field values
`define MODE_BIDIR      16'h0001
`define UNIT_WORD       16'h0000
`define SUM_DISABLED    16'h0001
`define POLICY_INVALID  8'h01

// error codes
`define ERR_NONE        16'h0000
`define ERR_SIMUL       16'h0003
`define ERR_LEN         16'h0010
`define ERR_SUM         16'h0011
`define ERR_LINE        16'h0012
`define ERR_TIMEOUT     16'h0013

// timing
`define CLK_HZ          20000000
`define TIMEOUT_UNIT_MS 100
`define TICK_CYCLES     (`TIMEOUT_UNIT_MS * (`CLK_HZ / 1000))

`endif

/* hdl/tick_timer.v */
// response timeout counter in 100 ms units
`timescale 1ns/1ps
module tick_timer #(
   parameter TICK_CYCLES = 2000000
) (
   input  wire        clk,     // core clock
   input  wire        rst_n,   // synchronised reset, active low
   input  wire        start,   // begin timing
   input  wire        stop,    // abandon timing
   input  wire [15:0] limit,   // units, zero disables
   output reg         expired  // one-cycle pulse
);
   reg [31:0] pre_reg;
   reg [15:0] ticks_reg;
   reg        run_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg   <= 32'h0000_0000;
         ticks_reg <= 16'h0000;
         run_reg   <= 1'b0;
         expired   <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            run_reg   <= (limit != 16'h0000);
            pre_reg   <= 32'h0000_0000;
            ticks_reg <= 16'h0000;
         end else if (stop) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            if (pre_reg == TICK_CYCLES - 1) begin
               pre_reg <= 32'h0000_0000;
               if (ticks_reg + 16'h0001 == limit) begin
                  run_reg <= 1'b0;
                  expired <= 1'b1;
               end else begin
                  ticks_reg <= ticks_reg + 16'h0001;
               end
            end else begin
               pre_reg <= pre_reg + 32'h0000_0001;
            end
         end
      end
   end
endmodule // tick_timer

/* tb/bidir_msg_engine_props.sv */
// port assertions for the message engine
`timescale 1ns/1ps
module msg_engine_checker #(parameter TICK_CYCLES = 20) (
   input wire        core_clk,          // clock
   input wire        arst_n,            // reset
   input wire        cpu_rd,            // read
   input wire [15:0] cpu_rdata,         // rdata
   input wire        send_request,      // send ask
   input wire        send_complete_bit, // send done
   input wire        recv_read_request, // msg ready
   input wire        recv_read_done,    // msg taken
   input wire        rx_valid,          // rx strobe
   input wire        rx_error,          // rx fault
   input wire [7:0]  tx_data,           // tx byte
   input wire        tx_valid,          // tx offer
   input wire        tx_ready           // tx take
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_send_start; $rose(send_request) && !send_complete_bit; endsequence
   sequence s_enq_out; ##[1:4] (tx_valid && tx_data == 8'h05); endsequence
   sequence s_nak_out; ##[1:300] (tx_valid && tx_data == 8'h15); endsequence
   a_enq_opens: assert property (s_send_start |-> s_enq_out)
      else $error("no enquiry");
   a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte moved");
   a_rdata_stands: assert property (!cpu_rd |=> $stable(cpu_rdata))
      else $error("rdata moved");
   a_done_holds: assert property (send_complete_bit && send_request |=> send_complete_bit)
      else $error("done dropped");
   a_done_clears: assert property (send_complete_bit && !send_request |=> !send_complete_bit)
      else $error("done stuck");
   a_done_cause: assert property ($rose(send_complete_bit) |-> $past(send_request))
      else $error("done unasked");
   a_error_naks: assert property (rx_valid && rx_error |-> s_nak_out)
      else $error("no nak");
   a_read_clears: assert property (recv_read_request && recv_read_done |=> !recv_read_request)
      else $error("read req stuck");
endmodule // msg_engine_checker
bind bidir_msg_engine msg_engine_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk, .arst_n, .cpu_rd,
   .cpu_rdata, .send_request, .send_complete_bit, .recv_read_request, .recv_read_done, .rx_valid,
   .rx_error, .tx_data, .tx_valid, .tx_ready);

/* tb/host_model.sv */
// host computer model on the serial side
`timescale 1ns/1ps
module host_model (
   input  wire       core_clk, // clock
   input  wire [7:0] tx_data,  // from device
   input  wire       tx_valid, // offered
   output reg        tx_ready, // taken
   output reg  [7:0] rx_data,  // to device
   output reg        rx_valid, // strobe
   output reg        rx_error  // line fault
);
   logic [7:0] got[$];
   logic       slow = 1'b0;
   initial {tx_ready, rx_valid, rx_error, rx_data} = {3'b000, 8'hff};
   always @(negedge core_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
   always @(posedge core_clk) if (tx_valid && tx_ready) got.push_back(tx_data);
   task put(input logic [7:0] b, input logic err);
      @(negedge core_clk);
      {rx_data, rx_valid, rx_error} = {b, 1'b1, err};
      @(negedge core_clk);
      {rx_data, rx_valid, rx_error} = {~b, 2'b00}; // no stale byte
   endtask
   task nak(input logic [15:0] code);
      put(8'h15, 1'b0);
      put(code[7:0], 1'b0);
      put(code[15:8], 1'b0);
   endtask
   task msg(input logic [15:0] len, input int nb, input logic [7:0] base, input logic sum_on, input int bad);
      logic [15:0] sum;
      logic [7:0]  b;
      sum = len[7:0] + len[15:8];
      put(8'h05, 1'b0);
      put(len[7:0], 1'b0);
      put(len[15:8], 1'b0);
      for (int i = 0; i < nb; i++) begin
         b = base + i[7:0];
         put(b, i == bad);
         sum = sum + b;
      end
      if (sum_on) begin
         put(sum[7:0], 1'b0);
         put(sum[15:8], 1'b0);
      end
   endtask
endmodule // host_model

/* tb/test_bidir_msg_engine.sv */
// bench for the message engine
`timescale 1ns/1ps
module test_bidir_msg_engine;
   logic        core_clk = 1'b0, arst_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
   logic        send_request = 1'b0, recv_read_done = 1'b0;
   logic [11:0] cpu_addr = 12'h000;
   logic [15:0] cpu_wdata = 16'h0000;
   wire  [15:0] cpu_rdata;
   wire  [7:0]  rx_data, tx_data;
   wire         send_complete_bit, recv_read_request, rx_valid, rx_error, tx_valid, tx_ready;
   int          n_mismatch = 0, checks_done = 0;
   always #25 core_clk = ~core_clk;
   bidir_msg_engine #(.TICK_CYCLES(20)) DUT (.core_clk, .arst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
      .cpu_rdata, .send_request, .send_complete_bit, .recv_read_request, .recv_read_done, .rx_data,
      .rx_valid, .rx_error, .tx_data, .tx_valid, .tx_ready);
   host_model H (.core_clk, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_error);
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task limit(input int i);
      if (i >= 400) begin
         n_mismatch++;
         $display("Error at %0t: wait timed out", $time);
         print_verdict();
      end
   endtask
   task wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge core_clk);
      {cpu_addr, cpu_wdata, cpu_wr} = {a, d, 1'b1};
      @(negedge core_clk);
      cpu_wr = 1'b0;
   endtask
   task rdc(input logic [11:0] a, input logic [15:0] exp);
      @(negedge core_clk);
      {cpu_addr, cpu_rd} = {a, 1'b1};
      @(negedge core_clk);
      cpu_rd = 1'b0;
      chk(cpu_rdata, exp);
   endtask
   task txq(input logic [7:0] e[$]);
      int i;
      for (i = 0; i < 400 && H.got.size() < e.size(); i++) @(negedge core_clk);
      limit(i);
      foreach (e[k]) chk({8'h00, H.got.pop_front()}, {8'h00, e[k]});
   endtask
   // mode 0 host acks, 1 host naks, 2 host message collides, 3 host stays silent
   task dev_send(input logic [7:0] e[$], input logic [15:0] code, input int mode, input logic [15:0] len);
      int i;
      @(negedge core_clk);
      send_request = 1'b1;
      fork
         txq(e);
         if (mode == 2) begin
            repeat (3) @(negedge core_clk);
            H.msg(len, 2 * len, 8'h30, 1'b0, 99);
         end
      join
      if (mode == 1) H.nak(code);
      if (mode == 0) H.put(8'h06, 1'b0);
      for (i = 0; i < 400 && send_complete_bit !== 1'b1; i++) @(negedge core_clk);
      limit(i);
      rdc(12'h116, code);
      send_request = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   initial begin
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      rdc(12'h114, 16'h0000);
      rdc(12'h11f, 16'h0000);
      $display("reset test done");
      H.msg(16'h0002, 4, 8'hfe, 1'b1, 99);
      txq('{8'h06});
      rdc(12'h080, 16'h0002);
      rdc(12'h081, 16'hfffe);
      rdc(12'h082, 16'h0100);
      chk({15'h0000, recv_read_request}, 16'h0001);
      @(negedge core_clk);
      recv_read_done = 1'b1;
      @(negedge core_clk);
      recv_read_done = 1'b0;
      H.msg(16'h0002, 4, 8'h10, 1'b1, 1);
      txq('{8'h15, 8'h12, 8'h00});
      H.msg(16'h0000, 0, 8'h00, 1'b1, 99);
      txq('{8'h15, 8'h10, 8'h00});
      rdc(12'h117, 16'h0010);
      // byte units; the next message's ENQ brings the receiver out of discard
      wr(12'h103, 16'h0001);
      H.msg(16'h0003, 3, 8'h40, 1'b1, 99);
      txq('{8'h06});
      rdc(12'h081, 16'h4140);
      rdc(12'h082, 16'h0042);
      rdc(12'h117, 16'h0000);
      wr(12'h103, 16'h0000);
      $display("receive test done");
      H.slow = 1'b1;
      wr(12'h112, 16'h0001);
      wr(12'h000, 16'h0001);
      wr(12'h001, 16'hff00);
      dev_send('{8'h05, 8'h01, 8'h00, 8'h00, 8'hff, 8'h00, 8'h01}, 16'h0000, 0, 16'h0000);
      wr(12'h115, 16'h0001);
      dev_send('{8'h05, 8'h01, 8'h00, 8'h00, 8'hff}, 16'h0042, 1, 16'h0000);
      wr(12'h113, 16'h0001);
      dev_send('{8'h05, 8'h01, 8'h00, 8'h00, 8'hff}, 16'h0013, 3, 16'h0000);
      $display("send test done");
      wr(12'h114, 16'h0100);
      dev_send('{8'h05, 8'h01, 8'h00, 8'h00, 8'hff}, 16'h0003, 2, 16'h0001);
      txq('{8'h06});
      rdc(12'h080, 16'h0001);
      wr(12'h114, 16'h0101);
      dev_send('{8'h05, 8'h01, 8'h00, 8'h00, 8'hff}, 16'h0003, 2, 16'h0002);
      repeat (20) @(negedge core_clk);
      chk(16'(H.got.size()), 16'h0000);
      rdc(12'h080, 16'h0001);
      $display("collision test done");
      print_verdict();
   end
endmodule // test_bidir_msg_engine
